// ---- logic/fine_clamp_gain_offset.sv ----
// Fine clamp timing, HSYNC output width, gain/offset datapath and its FIFO
`timescale 1ns/10ps

// ----------------------------------------------------------------------
// Small synchronous FIFO with valid/ready on both sides
// ----------------------------------------------------------------------
module pixel_fifo
#(
   parameter int WIDTH = 30,
   parameter int DEPTH = 4
)
(
   // Clock, reset, enable
   input  wire logic             sys_clk_i,
   input  wire logic             rst_i,
   input  wire logic             ce_i,
   // Fill side
   input  wire logic             wr_valid_i,
   output logic                  wr_ready_o,
   input  wire logic [WIDTH-1:0] wr_data_i,
   // Drain side
   output logic                  rd_valid_o,
   input  wire logic             rd_ready_i,
   output logic [WIDTH-1:0]      rd_data_o
);
   localparam int AW = $clog2(DEPTH);

   logic [WIDTH-1:0] mem [DEPTH];     // Storage words
   logic [AW-1:0]    wptr;            // Next write slot
   logic [AW-1:0]    rptr;            // Oldest word
   logic [AW:0]      count;           // Words held
   logic             push;
   logic             pop;

   // Honest flags straight from the occupancy count
   assign wr_ready_o = (count != (AW+1)'(DEPTH));
   assign rd_valid_o = (count != '0);
   assign rd_data_o  = mem[rptr];
   assign push       = ce_i && wr_valid_i && wr_ready_o;
   assign pop        = ce_i && rd_valid_o && rd_ready_i;

   // Storage write; no reset needed on data
   always_ff @(posedge sys_clk_i)
   begin
      if (push)
      begin
         mem[wptr] <= wr_data_i;
      end
   end

   // Pointers and occupancy
   always_ff @(posedge sys_clk_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         wptr  <= '0;
         rptr  <= '0;
         count <= '0;
      end
      else
      begin
         if (push)
         begin
            wptr <= (wptr == AW'(DEPTH-1)) ? '0 : wptr + 1'b1;
         end
         if (pop)
         begin
            rptr <= (rptr == AW'(DEPTH-1)) ? '0 : rptr + 1'b1;
         end
         count <= count + (AW+1)'(push) - (AW+1)'(pop);
      end
   end

endmodule // pixel_fifo

// ----------------------------------------------------------------------
// Top: register file, clamp/HSYNC timing, per-channel conditioning
// ----------------------------------------------------------------------
module fine_clamp_gain_offset
(
   // Clock, reset, enable
   input  wire logic                     sys_clk_i,
   input  wire logic                     rst_i,
   input  wire logic                     ce_i,
   // Register port
   input  wire fine_clamp_pkg::reg_req_s reg_req_i,
   output logic [7:0]                    reg_rdata_o,
   // Sync timing
   input  wire logic                     hsync_ref_i,
   input  wire logic                     ext_clamp_i,
   output logic                          fine_clamp_o,
   output logic                          hsync_output_pulse_o,
   // Samples from the converters
   input  wire logic                     in_valid_i,
   output logic                          in_ready_o,
   input  wire fine_clamp_pkg::pixel_s   in_pixel_i,
   // Conditioned samples downstream
   output logic                          out_valid_o,
   input  wire logic                     out_ready_i,
   output fine_clamp_pkg::pixel_s        out_pixel_o
);
   localparam int NC = fine_clamp_pkg::NUM_CH;
   localparam int LW = fine_clamp_pkg::OFFS_LOW_W;

   // ---------------------------------------------------------------
   // Registers
   // ---------------------------------------------------------------
   logic [7:0]    clamp_start_position;   // Pixels after edge
   logic [7:0]    clamp_pulse_width;      // Clamp length in pixels
   logic [7:0]    hsync_out_pulse_width;  // HSYNC output length
   logic [7:0]    gain_fine  [NC];        // Blue, green, red gain
   logic [7:0]    offs_upper [NC];        // Offset bits 9..2
   logic [NC*LW-1:0] offs_low;            // Shared offset LSBs
   logic          clamp_source_select;    // 1 = external clamp
   logic [NC-1:0] clamp_level_mid;        // 1 = mid-level clamp

   // Host writes; each register holds until rewritten
   always_ff @(posedge sys_clk_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         clamp_start_position  <= fine_clamp_pkg::RST_CLAMP_START;
         clamp_pulse_width     <= fine_clamp_pkg::RST_CLAMP_WIDTH;
         hsync_out_pulse_width <= fine_clamp_pkg::RST_HSYNC_OUTPUT_PULSE_WIDTH;
         for (int c = 0; c < NC; c++)
         begin
            gain_fine[c]  <= fine_clamp_pkg::RST_GAIN;
            offs_upper[c] <= fine_clamp_pkg::RST_OFFS_UPPER;
         end
         offs_low            <= '0;
         clamp_source_select <= fine_clamp_pkg::RST_CLAMP_SRC;
         clamp_level_mid     <= fine_clamp_pkg::RST_CLAMP_LEVEL;
      end
      else if (ce_i && reg_req_i.wr)
      begin
         case (reg_req_i.addr)
            fine_clamp_pkg::ADDR_CLAMP_START:
               clamp_start_position <= reg_req_i.wdata;
            fine_clamp_pkg::ADDR_CLAMP_WIDTH:
               clamp_pulse_width <= reg_req_i.wdata;
            fine_clamp_pkg::ADDR_HSYNC_OUTPUT_PULSE_WIDTH:
               hsync_out_pulse_width <= reg_req_i.wdata;
            fine_clamp_pkg::ADDR_GAIN_BLUE:  gain_fine[0] <= reg_req_i.wdata;
            fine_clamp_pkg::ADDR_GAIN_GREEN: gain_fine[1] <= reg_req_i.wdata;
            fine_clamp_pkg::ADDR_GAIN_RED:   gain_fine[2] <= reg_req_i.wdata;
            fine_clamp_pkg::ADDR_OFFS_BLUE:  offs_upper[0] <= reg_req_i.wdata;
            fine_clamp_pkg::ADDR_OFFS_GREEN: offs_upper[1] <= reg_req_i.wdata;
            fine_clamp_pkg::ADDR_OFFS_RED:   offs_upper[2] <= reg_req_i.wdata;
            fine_clamp_pkg::ADDR_OFFS_LOW:
               offs_low <= reg_req_i.wdata[NC*LW-1:0];
            fine_clamp_pkg::ADDR_CLAMP_CTRL:
               clamp_source_select <=
                  reg_req_i.wdata[fine_clamp_pkg::CLAMP_SRC_BIT];
            fine_clamp_pkg::ADDR_CLAMP_LEVEL:
               clamp_level_mid <= reg_req_i.wdata[NC-1:0];
            default: ;  // Unmapped offsets ignore writes
         endcase
      end
   end

   // Readback, one cycle after the read strobe; unmapped reads zero
   always_ff @(posedge sys_clk_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         reg_rdata_o <= 8'h00;
      end
      else if (ce_i && reg_req_i.rd)
      begin
         case (reg_req_i.addr)
            fine_clamp_pkg::ADDR_CLAMP_START:
               reg_rdata_o <= clamp_start_position;
            fine_clamp_pkg::ADDR_CLAMP_WIDTH: reg_rdata_o <= clamp_pulse_width;
            fine_clamp_pkg::ADDR_HSYNC_OUTPUT_PULSE_WIDTH:
               reg_rdata_o <= hsync_out_pulse_width;
            fine_clamp_pkg::ADDR_GAIN_BLUE:   reg_rdata_o <= gain_fine[0];
            fine_clamp_pkg::ADDR_GAIN_GREEN:  reg_rdata_o <= gain_fine[1];
            fine_clamp_pkg::ADDR_GAIN_RED:    reg_rdata_o <= gain_fine[2];
            fine_clamp_pkg::ADDR_OFFS_BLUE:   reg_rdata_o <= offs_upper[0];
            fine_clamp_pkg::ADDR_OFFS_GREEN:  reg_rdata_o <= offs_upper[1];
            fine_clamp_pkg::ADDR_OFFS_RED:    reg_rdata_o <= offs_upper[2];
            fine_clamp_pkg::ADDR_OFFS_LOW:    reg_rdata_o <= 8'(offs_low);
            fine_clamp_pkg::ADDR_CLAMP_CTRL:
               reg_rdata_o <= 8'(clamp_source_select)
                              << fine_clamp_pkg::CLAMP_SRC_BIT;
            fine_clamp_pkg::ADDR_CLAMP_LEVEL:
               reg_rdata_o <= 8'(clamp_level_mid);
            default:                          reg_rdata_o <= 8'h00;
         endcase
      end
   end

   // ---------------------------------------------------------------
   // Pixel counter from the HSYNC reference edge
   // ---------------------------------------------------------------
   logic [8:0] pix_cnt;    // Pixels since the edge
   logic       line_run;   // Counter meaningful since last edge

   // Counter restarts at each edge and parks at its top value
   always_ff @(posedge sys_clk_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         pix_cnt  <= '0;
         line_run <= 1'b0;
      end
      else if (ce_i)
      begin
         if (hsync_ref_i)
         begin
            pix_cnt  <= '0;
            line_run <= 1'b1;
         end
         else if (pix_cnt != fine_clamp_pkg::CNT_MAX)
         begin
            pix_cnt <= pix_cnt + 1'b1;
         end
         else
         begin
            line_run <= 1'b0;  // Parked; no pulse until next edge
         end
      end
   end

   // Window compare; sum is nine bits so start+width never wraps
   logic [8:0] clamp_end;
   logic       clamp_win;
   logic       hsync_output_pulse_win;
   assign clamp_end = {1'b0, clamp_start_position} + {1'b0, clamp_pulse_width};
   assign clamp_win = line_run
                      && (pix_cnt >= {1'b0, clamp_start_position})
                      && (pix_cnt < clamp_end);
   assign hsync_output_pulse_win = line_run
                      && (pix_cnt < {1'b0, hsync_out_pulse_width});

   // Registered timing outputs; external clamp bypasses the window
   always_ff @(posedge sys_clk_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         fine_clamp_o         <= 1'b0;
         hsync_output_pulse_o <= 1'b0;
      end
      else if (ce_i)
      begin
         fine_clamp_o <= clamp_source_select ? ext_clamp_i
                                             : clamp_win;
         hsync_output_pulse_o <= hsync_output_pulse_win;
      end
   end

   // ---------------------------------------------------------------
   // Per-channel gain, offset and saturation
   // ---------------------------------------------------------------
   // Mid-level channels scale about the 512 blank so blank stays put
   function automatic logic [9:0] condition(input logic [9:0] s,
                                            input logic [7:0] g,
                                            input logic [9:0] off,
                                            input logic       mid);
      logic [9:0]         base;
      logic [8:0]         gs;
      logic signed [11:0] d;
      logic signed [21:0] p;
      logic signed [13:0] v;
      base = mid ? fine_clamp_pkg::MID_LEVEL : 10'h000;
      gs   = {1'b0, g} + fine_clamp_pkg::GAIN_UNITY;
      d    = $signed({2'b00, s}) - $signed({2'b00, base});
      p    = d * $signed({2'b00, gs});
      v    = 14'(p >>> fine_clamp_pkg::GAIN_SHIFT)
             + $signed({4'h0, base})
             + $signed({4'h0, off})
             - $signed({4'h0, fine_clamp_pkg::OFFSET_ZERO});
      if (v < 0)
         return 10'h000;
      else if (v > $signed({4'h0, fine_clamp_pkg::SAMPLE_MAX}))
         return fine_clamp_pkg::SAMPLE_MAX;
      else
         return v[9:0];
   endfunction

   fine_clamp_pkg::pixel_s cond_pixel;   // Result into the FIFO

   generate
      for (genvar c = 0; c < NC; c++)
      begin : g_chan
         // Offset word: own upper byte above its own LSB pair from the shared register
         assign cond_pixel.ch[c] = condition(in_pixel_i.ch[c], gain_fine[c],
                                       {offs_upper[c], offs_low[c*LW +: LW]},
                                       clamp_level_mid[c]);
      end
   endgenerate

   // ---------------------------------------------------------------
   // Output FIFO; a full FIFO stalls the converter side
   // ---------------------------------------------------------------
   pixel_fifo
   #(
      .WIDTH ($bits(fine_clamp_pkg::pixel_s)),
      .DEPTH (fine_clamp_pkg::FIFO_DEPTH)
   )
   u_fifo
   (
      .sys_clk_i  (sys_clk_i),
      .rst_i      (rst_i),
      .ce_i       (ce_i),
      .wr_valid_i (in_valid_i),
      .wr_ready_o (in_ready_o),
      .wr_data_i  (cond_pixel),
      .rd_valid_o (out_valid_o),
      .rd_ready_i (out_ready_i),
      .rd_data_o  (out_pixel_o)
   );

   // ---------------------------------------------------------------
   // Assertions
   // ---------------------------------------------------------------
   // Unity gain and zero offset on blue; holds for either clamp level
   logic def_regs;
   assign def_regs = (gain_fine[0] == 8'h00) && (offs_upper[0] == 8'h80)
                     && (offs_low[1:0] == 2'h0);

   property p_clamp_start;
      @(posedge sys_clk_i) disable iff (rst_i)
      (ce_i && !clamp_source_select && line_run && !hsync_ref_i
       && clamp_pulse_width != 8'h00
       && pix_cnt == {1'b0, clamp_start_position}) |=> fine_clamp_o;
   endproperty
   a_clamp_start: assert property (p_clamp_start)
      else $error("clamp not raised at start position");

   property p_clamp_before;
      @(posedge sys_clk_i) disable iff (rst_i)
      (ce_i && !clamp_source_select && line_run
       && pix_cnt < {1'b0, clamp_start_position}) |=> !fine_clamp_o;
   endproperty
   a_clamp_before: assert property (p_clamp_before)
      else $error("clamp raised before start position");

   property p_clamp_ext;
      @(posedge sys_clk_i) disable iff (rst_i)
      (ce_i && clamp_source_select) |=> fine_clamp_o == $past(ext_clamp_i);
   endproperty
   a_clamp_ext: assert property (p_clamp_ext)
      else $error("external clamp not followed");

   property p_clamp_end;
      @(posedge sys_clk_i) disable iff (rst_i)
      (ce_i && !clamp_source_select && pix_cnt == clamp_end) |=> !fine_clamp_o;
   endproperty
   a_clamp_end: assert property (p_clamp_end)
      else $error("clamp longer than programmed width");

   property p_hsync_output_pulse_width;
      @(posedge sys_clk_i) disable iff (rst_i)
      (ce_i && hsync_ref_i && hsync_out_pulse_width == 8'h04) ##1 ce_i [*5]
      |=> $past(hsync_output_pulse_o, 4) && !hsync_output_pulse_o;
   endproperty
   a_hsync_output_pulse_width: assert property (p_hsync_output_pulse_width)
      else $error("hsync output width wrong");

   property p_unity;
      @(posedge sys_clk_i) disable iff (rst_i)
      def_regs |-> cond_pixel.ch[0] == in_pixel_i.ch[0];
   endproperty
   a_unity: assert property (p_unity)
      else $error("default settings alter blue sample");

   property p_gain_half;
      @(posedge sys_clk_i) disable iff (rst_i)
      (gain_fine[1] == 8'h80 && offs_upper[1] == 8'h80
       && offs_low[3:2] == 2'h0 && !clamp_level_mid[1]
       && in_pixel_i.ch[1] == 10'h12c) |-> cond_pixel.ch[1] == 10'h1c2;
   endproperty
   a_gain_half: assert property (p_gain_half)
      else $error("gain 80h not 1.5");

   property p_offset_step;
      @(posedge sys_clk_i) disable iff (rst_i)
      (gain_fine[2] == 8'h00 && offs_upper[2] == 8'h00
       && offs_low[5:4] == 2'h1 && !clamp_level_mid[2]
       && in_pixel_i.ch[2] == 10'h200) |-> cond_pixel.ch[2] == 10'h001;
   endproperty
   a_offset_step: assert property (p_offset_step)
      else $error("offset composition wrong");

   property p_mid_blank;
      @(posedge sys_clk_i) disable iff (rst_i)
      (clamp_level_mid[0] && offs_upper[0] == 8'h80 && offs_low[1:0] == 2'h0
       && in_pixel_i.ch[0] == fine_clamp_pkg::MID_LEVEL)
      |-> cond_pixel.ch[0] == fine_clamp_pkg::MID_LEVEL;
   endproperty
   a_mid_blank: assert property (p_mid_blank)
      else $error("mid-level blank moved");

   property p_saturate;
      @(posedge sys_clk_i) disable iff (rst_i)
      (gain_fine[0] >= 8'h80 && offs_upper[0] >= 8'h80
       && in_pixel_i.ch[0] >= 10'h3e8) |-> cond_pixel.ch[0] == 10'h3ff;
   endproperty
   a_saturate: assert property (p_saturate)
      else $error("result wrapped instead of saturating");

   c_clamp_rise: cover property (@(posedge sys_clk_i) disable iff (rst_i)
      !fine_clamp_o ##1 fine_clamp_o);
   c_fifo_full: cover property (@(posedge sys_clk_i) disable iff (rst_i)
      !in_ready_o);
   c_ext_clamp: cover property (@(posedge sys_clk_i) disable iff (rst_i)
      clamp_source_select && fine_clamp_o);

endmodule // fine_clamp_gain_offset

// ---- logic/fine_clamp_pkg.sv ----
// Constants, register map and carriers for the fine clamp/gain/offset stage
// ----------------------------------------------------------------------
// Summary of operation
// - Clamp starts programmed pixels after HSYNC edge
// - External clamp selected ignores programmed start
// - Clamp lasts programmed width pixels from start
// - HSYNC output active for programmed pixel width
// - Independent 8-bit fine gain per colour channel
// - Gain equals one plus code over 256
// - 10-bit offset: upper per channel, shared LSBs
// - Offset code is offset binary, 80h zero
// - Default offset gives blank 0 or 512
// - Clamp source bit picks internal or external
// - Per-channel bottom or mid clamp level select
// ----------------------------------------------------------------------
package fine_clamp_pkg;

   // ---------------------------------------------------------------
   // Register offsets
   // ---------------------------------------------------------------
   localparam logic [7:0] ADDR_CLAMP_START  = 8'h05;
   localparam logic [7:0] ADDR_CLAMP_WIDTH  = 8'h06;
   localparam logic [7:0] ADDR_HSYNC_OUTPUT_PULSE_WIDTH  = 8'h07;
   localparam logic [7:0] ADDR_GAIN_BLUE    = 8'h08;
   localparam logic [7:0] ADDR_GAIN_GREEN   = 8'h09;
   localparam logic [7:0] ADDR_GAIN_RED     = 8'h0a;
   localparam logic [7:0] ADDR_OFFS_BLUE    = 8'h0b;
   localparam logic [7:0] ADDR_OFFS_GREEN   = 8'h0c;
   localparam logic [7:0] ADDR_OFFS_RED     = 8'h0d;
   localparam logic [7:0] ADDR_CLAMP_CTRL   = 8'h0f;
   localparam logic [7:0] ADDR_CLAMP_LEVEL  = 8'h10;
   localparam logic [7:0] ADDR_OFFS_LOW     = 8'h1d;

   // ---------------------------------------------------------------
   // Reset values
   // ---------------------------------------------------------------
   localparam logic [7:0] RST_CLAMP_START   = 8'h32;
   localparam logic [7:0] RST_CLAMP_WIDTH   = 8'h20;
   localparam logic [7:0] RST_HSYNC_OUTPUT_PULSE_WIDTH   = 8'h20;
   localparam logic [7:0] RST_GAIN          = 8'h00;
   localparam logic [7:0] RST_OFFS_UPPER    = 8'h80;
   localparam logic [1:0] RST_OFFS_LOW      = 2'h0;
   localparam logic       RST_CLAMP_SRC     = 1'b0;
   localparam logic [2:0] RST_CLAMP_LEVEL   = 3'h5;

   // ---------------------------------------------------------------
   // Field positions
   // ---------------------------------------------------------------
   localparam int CLAMP_SRC_BIT  = 7;   // In the clamp control register
   localparam int OFFS_LOW_W     = 2;   // LSB pair width per channel

   // ---------------------------------------------------------------
   // Datapath sizes and arithmetic constants
   // ---------------------------------------------------------------
   localparam int           NUM_CH      = 3;   // 0 blue, 1 green, 2 red
   localparam int           SAMPLE_W    = 10;
   localparam int           CNT_W       = 9;
   localparam logic [8:0]   CNT_MAX     = 9'h1ff;
   localparam logic [8:0]   GAIN_UNITY  = 9'h100;
   localparam int           GAIN_SHIFT  = 8;
   localparam logic [9:0]   MID_LEVEL   = 10'h200;
   localparam logic [9:0]   OFFSET_ZERO = 10'h200;
   localparam logic [9:0]   SAMPLE_MAX  = 10'h3ff;
   localparam int           FIFO_DEPTH  = 4;

   // ---------------------------------------------------------------
   // Carriers
   // ---------------------------------------------------------------
   typedef struct packed {
      logic       wr;      // Write strobe
      logic       rd;      // Read strobe
      logic [7:0] addr;    // Register offset
      logic [7:0] wdata;   // Write data
   } reg_req_s;

   typedef struct packed {
      logic [NUM_CH-1:0][SAMPLE_W-1:0] ch;   // Index 0 blue, 2 red
   } pixel_s;

endpackage

// ---- tb/fine_clamp_gain_offset_tb.sv ----
// Self-checking bench for the fine clamp, gain and offset stage
`timescale 1ns/10ps

module fine_clamp_gain_offset_tb;
   // --------------------------------------------------------------
   // Stimulus and observation signals
   // --------------------------------------------------------------
   logic sys_clk = 1'b0, rst = 1'b1, hs = 1'b0, ext = 1'b0;
   logic iv = 1'b0, stall = 1'b0, in_ready, out_valid, ready;
   logic ce = 1'b1;
   logic clamp, hso;
   logic [7:0] rdata, pops, n;
   fine_clamp_pkg::reg_req_s req = '0;
   fine_clamp_pkg::pixel_s   pix = '0, opix, last;
   int err_total = 0, samples_checked = 0;
   // One conditioning case: register write, input level, result
   typedef struct packed {
      logic [7:0] a, d;
      logic [9:0] s;
      logic [29:0] e;
   } row_s;
   row_s rows [9] = '{
      '{8'h08, 8'h00, 10'd300, {10'd300, 10'd300, 10'd300}},
      '{8'h09, 8'h80, 10'd300, {10'd300, 10'd450, 10'd300}},
      '{8'h08, 8'h80, 10'd300, {10'd300, 10'd450, 10'd194}},
      '{8'h0d, 8'h81, 10'd300, {10'd304, 10'd450, 10'd194}},
      '{8'h0c, 8'h7f, 10'd1000, {10'd1004, 10'd1023, 10'd1023}},
      '{8'h0d, 8'h00, 10'd0, {10'd0, 10'd0, 10'd0}},
      '{8'h10, 8'h00, 10'd512, {10'd0, 10'd764, 10'd768}},
      '{8'h1d, 8'h15, 10'd512, {10'd1, 10'd765, 10'd769}},
      '{8'h10, 8'h07, 10'd512, {10'd1, 10'd509, 10'd513}}};

   always #20 sys_clk = ~sys_clk;

   fine_clamp_gain_offset DUT (.sys_clk_i(sys_clk), .rst_i(rst),
      .ce_i(ce), .reg_req_i(req), .reg_rdata_o(rdata),
      .hsync_ref_i(hs), .ext_clamp_i(ext), .fine_clamp_o(clamp),
      .hsync_output_pulse_o(hso), .in_valid_i(iv), .in_ready_o(in_ready),
      .in_pixel_i(pix), .out_valid_o(out_valid), .out_ready_i(ready),
      .out_pixel_o(opix));
   pixel_sink sink (.sys_clk_i(sys_clk), .rst_i(rst), .stall_i(stall),
      .valid_i(out_valid), .pixel_i(opix), .ready_o(ready),
      .last_o(last), .pops_o(pops));

   // --------------------------------------------------------------
   // Shared tasks
   // --------------------------------------------------------------
   task automatic chk(input string nm, input logic [31:0] seen, exp);
      samples_checked++;
      if (seen !== exp)
      begin
         err_total++;
         $display("wrong value %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic wr(input logic [7:0] a, d);
      @(posedge sys_clk) req <= '{1'b1, 1'b0, a, d};
      @(posedge sys_clk) req <= '0;
   endtask
   task automatic rd(input logic [7:0] a, e);
      @(posedge sys_clk) req <= '{1'b0, 1'b1, a, 8'h00};
      @(posedge sys_clk) req <= '0;
      #1 chk("rdata", {24'h0, rdata}, {24'h0, e});
   endtask
   // Push one sample on all channels, wait for the sink to take it
   task automatic px(input logic [9:0] s, input logic [29:0] e);
      n = pops;
      @(posedge sys_clk) iv <= 1'b1;
      pix <= {s, s, s};
      @(posedge sys_clk) iv <= 1'b0;
      for (int i = 0; i < 10 && pops == n; i++) @(posedge sys_clk);
      #1 chk("pixel", {2'h0, last}, {2'h0, e});
   endtask
   // One line: sync edge, then a bit per cycle for both pulses
   task automatic line_chk(input logic [31:0] ec, eh);
      logic [31:0] cv, hv;
      cv = '0;
      hv = '0;
      @(posedge sys_clk) hs <= 1'b1;
      @(posedge sys_clk) hs <= 1'b0;
      for (int k = 1; k < 32; k++)
      begin
         @(posedge sys_clk);
         #1 cv[k] = clamp;
         hv[k] = hso;
      end
      chk("fine_clamp", cv, ec);
      chk("hsync_out", hv, eh);
   endtask
   task automatic report_and_stop();
      $display("checks %0d errors %0d", samples_checked, err_total);
      if (err_total == 0 && samples_checked > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask

   // --------------------------------------------------------------
   // Main sequence
   // --------------------------------------------------------------
   initial
   begin
      repeat (2) @(posedge sys_clk);
      rst <= 1'b0;
      // Table of conditioning cases, settings accumulate row by row
      foreach (rows[i])
      begin
         wr(rows[i].a, rows[i].d);
         px(rows[i].s, rows[i].e);
      end
      // Reset in mid-run must restore the defaults of the registers read back below
      @(posedge sys_clk) rst <= 1'b1;
      repeat (2) @(posedge sys_clk);
      rst <= 1'b0;
      rd(8'h05, 8'h32);
      rd(8'h06, 8'h20);
      rd(8'h07, 8'h20);
      rd(8'h0a, 8'h00);
      rd(8'h0c, 8'h80);
      rd(8'h0f, 8'h00);
      rd(8'h10, 8'h05);
      rd(8'h1d, 8'h00);
      rd(8'h0e, 8'h00);
      px(10'd512, {10'd512, 10'd512, 10'd512});
      // Let the pixel counter park before timing the pulses
      repeat (520) @(posedge sys_clk);
      wr(8'h05, 8'h06);
      wr(8'h06, 8'h10);
      wr(8'h07, 8'h04);
      line_chk(32'h007fff80, 32'h0000001e);
      // External clamp source: programmed start has no effect
      wr(8'h0f, 8'h80);
      rd(8'h0f, 8'h80);
      line_chk(32'h0, 32'h0000001e);
      @(posedge sys_clk) ext <= 1'b1;
      @(posedge sys_clk);
      #1 chk("ext_clamp", {31'h0, clamp}, 32'h1);
      @(posedge sys_clk) ext <= 1'b0;
      @(posedge sys_clk);
      #1 chk("ext_clamp", {31'h0, clamp}, 32'h0);
      // Fill the buffer against a stalled sink, then drain it
      @(posedge sys_clk) stall <= 1'b1;
      n = pops;
      @(posedge sys_clk) iv <= 1'b1;
      repeat (6) @(posedge sys_clk);
      #1 chk("in_ready", {31'h0, in_ready}, 32'h0);
      @(posedge sys_clk) iv <= 1'b0;
      stall <= 1'b0;
      for (int i = 0; i < 20 && out_valid !== 1'b0; i++) @(posedge sys_clk);
      @(posedge sys_clk);
      #1 chk("pops", {24'h0, pops - n}, 32'h4);
      chk("out_valid", {31'h0, out_valid}, 32'h0);
      // Clock enable low: a register write must be ignored
      @(posedge sys_clk) ce <= 1'b0;
      wr(8'h05, 8'h77);
      @(posedge sys_clk) ce <= 1'b1;
      rd(8'h05, 8'h06);
      report_and_stop();
   end

   // Watchdog: the whole run needs well under 2000 cycles
   initial
   begin
      repeat (4000) @(posedge sys_clk);
      err_total++;
      report_and_stop();
   end
endmodule // fine_clamp_gain_offset_tb

// ---- tb/pixel_sink.sv ----
// Downstream consumer model for conditioned pixels, with a stall control
`timescale 1ns/10ps

module pixel_sink
(
   // Clock and reset
   input  wire logic                   sys_clk_i,
   input  wire logic                   rst_i,
   // Test control
   input  wire logic                   stall_i,
   // Pixel stream
   input  wire logic                   valid_i,
   input  wire fine_clamp_pkg::pixel_s pixel_i,
   output logic                        ready_o,
   // Observation
   output fine_clamp_pkg::pixel_s      last_o,
   output logic [7:0]                  pops_o
);
   // --------------------------------------------------------------
   // Ready lags the stall request by a cycle, like a slow consumer
   // --------------------------------------------------------------
   always_ff @(posedge sys_clk_i or posedge rst_i)
      if (rst_i)
         ready_o <= 1'b0;
      else
         ready_o <= ~stall_i;

   // Capture each word taken and count the takes
   always_ff @(posedge sys_clk_i or posedge rst_i)
      if (rst_i)
         pops_o <= 8'h00;
      else if (valid_i && ready_o)
      begin
         pops_o <= pops_o + 8'h01;
         last_o <= pixel_i;
      end
endmodule // pixel_sink
